// ---- common/supply_mode_pkg.sv ----
package supply_mode_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int DGL_TIME_US = 200;
  localparam int DGL_CYCLES = DGL_TIME_US * CLK_MHZ;
  localparam int DGL_W = 15;
  localparam int WD_TIME_MS = 32;
  localparam int WD_CYCLES = WD_TIME_MS * 1000 * CLK_MHZ;
  localparam int WD_W = 22;

  // Register byte offsets
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] EVT_ADDR = 8'h08;
  localparam logic [7:0] MASK_ADDR = 8'h0c;

  // Control fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_WD_BIT = 1;
  localparam int CTRL_EN_LSB = 2;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // Status fields
  localparam int ST_FORCE_BIT = 0;
  localparam int ST_SERF_BIT = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_CLKPIN_BIT = 5;
  localparam int ST_BAT_BIT = 6;
  localparam int ST_LOG_BIT = 7;
  localparam int ST_GND_BIT = 8;

  // Event fields: 7:0 faults, then fail entry and watchdog timeout
  localparam int EVT_W = 10;
  localparam int EVT_FAIL_BIT = 8;
  localparam int EVT_WD_BIT = 9;
  localparam logic [9:0] EVT_RST = 10'h000;

  // Synchronised pin vector layout
  localparam int PIN_W = 12;

  typedef enum logic [2:0] {
    MODE_POWER_OFF = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_FAIL = 3'b011,
    MODE_GND_LOSS = 3'b100
  } mode_t;
endpackage

// ---- verilog/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/deglitch_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module deglitch_filter
  import supply_mode_pkg::*;
#(
  parameter logic [DGL_W-1:0] HOLD_CYCLES = DGL_W'(DGL_CYCLES)
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic level_i,
  output logic level_o
);
  logic [DGL_W-1:0] cnt_r;

  // Symmetric filter: output follows only after a stable hold time
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      level_o <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= '0;
      level_o <= 1'b0;
    end else if (level_i == level_o) begin
      cnt_r <= '0;
    end else if (cnt_r >= HOLD_CYCLES) begin
      cnt_r <= '0;
      level_o <= level_i;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/supply_loss_and_fail_mode_control.sv ----
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module supply_loss_and_fail_mode_control
  import supply_mode_pkg::*;
#(
  parameter logic [DGL_W-1:0] DGL_HOLD = DGL_W'(DGL_CYCLES),
  parameter logic [WD_W-1:0] WD_LIMIT = WD_W'(WD_CYCLES)
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic battery_supply_ok_i,
  input wire logic logic_supply_ok_i,
  input wire logic ground_ok_i,
  input wire logic wake_i,
  input wire logic wake_by_reset_pin_i,
  input wire logic active_low_reset_pin_n_i,
  input wire logic fail_force_i,
  input wire logic [3:0] direct_channel_inputs_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  input wire logic [4:0] pwm_channel_i,
  input wire logic [7:0] fault_event_i,
  output logic [4:0] power_channel_outputs_o,
  output logic external_switch_control_output_o,
  output logic [2:0] mode_o,
  output logic irq_o
);
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic bat_ok;
  logic log_ok;
  logic gnd_ok;
  logic awake;
  logic wake_rst;
  logic rst_pin_n;
  logic force_s;
  logic [3:0] direct_s;
  logic clk_in_s;
  logic force_dgl;
  logic [3:0] direct_dgl;
  logic power_off;
  mode_t mode_r;
  mode_t mode_nxt;
  logic [6:0] ctrl_r;
  logic wd_last_r;
  logic [WD_W-1:0] wd_cnt_r;
  logic wd_fail_r;
  logic serial_fail_r;
  logic [EVT_W-1:0] evt_r;
  logic [EVT_W-1:0] mask_r;
  logic [EVT_W-1:0] evt_set;
  logic ack_r;
  logic req;
  logic acc;
  logic wr_ok;
  logic rd_clr;
  logic kick;
  logic wd_timeout;
  logic wd_run;
  logic [31:0] rd_data;

  // Pin inputs gathered for synchronisation
  assign pins_raw = {clk_pin_i, direct_channel_inputs_i, fail_force_i, active_low_reset_pin_n_i,
                     wake_by_reset_pin_i, wake_i, ground_ok_i, logic_supply_ok_i, battery_supply_ok_i};

  pin_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pins_raw),
    .sync_o(pins_s)
  );

  assign bat_ok = pins_s[0];
  assign log_ok = pins_s[1];
  assign gnd_ok = pins_s[2];
  assign awake = pins_s[3];
  assign wake_rst = pins_s[4];
  assign rst_pin_n = pins_s[5];
  assign force_s = pins_s[6];
  assign direct_s = pins_s[10:7];
  assign clk_in_s = pins_s[11];

  // Both supplies gone
  assign power_off = ~bat_ok & ~log_ok;

  // Forcing input deglitch
  deglitch_filter #(
    .HOLD_CYCLES(DGL_HOLD)
  ) u_force_dgl (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(power_off),
    .level_i(force_s),
    .level_o(force_dgl)
  );

  // Direct channel input deglitch
  for (genvar i = 0; i < 4; i++) begin : g_direct
    deglitch_filter #(
      .HOLD_CYCLES(DGL_HOLD)
    ) u_dir_dgl (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(power_off),
      .level_i(direct_s[i]),
      .level_o(direct_dgl[i])
    );
  end

  // Mode selection by fixed priority
  always_comb begin
    if (power_off) begin
      mode_nxt = MODE_POWER_OFF;
    end else if (!gnd_ok) begin
      mode_nxt = MODE_GND_LOSS;
    end else if (force_dgl || wd_fail_r) begin
      mode_nxt = MODE_FAIL;
    end else if (!awake) begin
      mode_nxt = MODE_SLEEP;
    end else begin
      mode_nxt = MODE_NORMAL;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_POWER_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Bus handshake
  assign req = wb_cyc_i & wb_stb_i;
  assign acc = req & ack_r;
  // Serial side is dead without logic supply
  assign wr_ok = acc & wb_we_i & log_ok;
  assign rd_clr = acc & ~wb_we_i & log_ok & (wb_adr_i == EVT_ADDR);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Control register: external switch, watchdog bit, channel enables
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= CTRL_RST;
    end else if (mode_r == MODE_POWER_OFF) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ok && wb_adr_i == CTRL_ADDR && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[6:0];
    end
  end

  // Mask register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_r <= EVT_RST;
    end else if (mode_r == MODE_POWER_OFF) begin
      mask_r <= EVT_RST;
    end else if (wr_ok && wb_adr_i == MASK_ADDR) begin
      if (wb_sel_i[0]) begin
        mask_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        mask_r[9:8] <= wb_dat_i[9:8];
      end
    end
  end

  // Watchdog kick is a toggle of the watchdog bit
  assign kick = wr_ok & (wb_adr_i == CTRL_ADDR) & wb_sel_i[0] & (wb_dat_i[CTRL_WD_BIT] != wd_last_r);
  assign wd_run = (mode_r == MODE_NORMAL) || (mode_r == MODE_FAIL);
  assign wd_timeout = wd_run & ~kick & (wd_cnt_r >= WD_LIMIT);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_last_r <= 1'b0;
    end else if (mode_r == MODE_POWER_OFF) begin
      wd_last_r <= 1'b0;
    end else if (kick) begin
      wd_last_r <= wb_dat_i[CTRL_WD_BIT];
    end
  end

  // Watchdog counter, expires when watchdog bit toggles stop
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_cnt_r <= '0;
    end else if (!wd_run || kick || wd_timeout) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // Watchdog fail request, lifted by a fresh kick
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_fail_r <= 1'b0;
    end else if (mode_r == MODE_POWER_OFF) begin
      wd_fail_r <= 1'b0;
    end else if (wd_timeout) begin
      wd_fail_r <= 1'b1;
    end else if (kick) begin
      wd_fail_r <= 1'b0;
    end
  end

  // Serial failure flag, held in fail, dropped on fail-to-normal
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_fail_r <= 1'b0;
    end else if (mode_r == MODE_POWER_OFF) begin
      serial_fail_r <= 1'b0;
    end else if (wd_timeout) begin
      serial_fail_r <= 1'b1;
    end else if (mode_r == MODE_FAIL && mode_nxt == MODE_NORMAL) begin
      serial_fail_r <= 1'b0;
    end
  end

  // Sticky events, set wins over read clear
  assign evt_set = {wd_timeout, (mode_nxt == MODE_FAIL) && (mode_r != MODE_FAIL), fault_event_i};

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_r <= EVT_RST;
    end else if (mode_r == MODE_POWER_OFF) begin
      evt_r <= EVT_RST;
    end else if (rd_clr) begin
      evt_r <= evt_set;
    end else begin
      evt_r <= evt_r | evt_set;
    end
  end

  // Interrupt level from unmasked events
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((evt_r | evt_set) & mask_r & {EVT_W{~rd_clr}} | evt_set & mask_r);
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      CTRL_ADDR: rd_data[6:0] = ctrl_r;
      STAT_ADDR: begin
        rd_data[ST_FORCE_BIT] = force_s;
        rd_data[ST_SERF_BIT] = serial_fail_r;
        rd_data[ST_MODE_LSB +: 3] = mode_r;
        rd_data[ST_CLKPIN_BIT] = clk_in_s;
        rd_data[ST_BAT_BIT] = bat_ok;
        rd_data[ST_LOG_BIT] = log_ok;
        rd_data[ST_GND_BIT] = gnd_ok;
      end
      EVT_ADDR: rd_data[EVT_W-1:0] = evt_r;
      MASK_ADDR: rd_data[EVT_W-1:0] = mask_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data registered with the acknowledge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !ack_r && !wb_we_i && log_ok) begin
      wb_dat_o <= rd_data;
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;

  // Power channel drive per mode
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_channel_outputs_o <= 5'h00;
    end else if (!bat_ok) begin
      power_channel_outputs_o <= 5'h00;
    end else begin
      unique case (mode_nxt)
        MODE_NORMAL: power_channel_outputs_o <= pwm_channel_i & ctrl_r[CTRL_EN_LSB +: 5];
        MODE_FAIL: power_channel_outputs_o <= {1'b0, direct_dgl};
        MODE_GND_LOSS: power_channel_outputs_o <= 5'h00;
        MODE_SLEEP: power_channel_outputs_o <= 5'h00;
        MODE_POWER_OFF: power_channel_outputs_o <= 5'h00;
      endcase
    end
  end

  // External switch follows config in normal with logic supply ok, battery loss included
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      external_switch_control_output_o <= 1'b0;
    end else begin
      external_switch_control_output_o <= ctrl_r[CTRL_EXT_BIT] & log_ok & (mode_nxt == MODE_NORMAL);
    end
  end

  // Wake report on the clock pin while reset pin is low
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_pin_o <= 1'b0;
      clk_pin_oe_o <= 1'b0;
    end else if (!rst_pin_n && awake && !wake_rst && bat_ok) begin
      clk_pin_o <= 1'b1;
      clk_pin_oe_o <= 1'b1;
    end else begin
      clk_pin_o <= 1'b0;
      clk_pin_oe_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_o <= MODE_POWER_OFF;
    end else begin
      mode_o <= mode_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- tb/supply_mode_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module supply_mode_checker
  import supply_mode_pkg::*;
#(
  parameter logic [DGL_W-1:0] DGL_HOLD = 15'h8
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic battery_supply_ok_i,
  input wire logic logic_supply_ok_i,
  input wire logic ground_ok_i,
  input wire logic wake_i,
  input wire logic wake_by_reset_pin_i,
  input wire logic active_low_reset_pin_n_i,
  input wire logic fail_force_i,
  input wire logic [4:0] pwm_channel_i,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_o,
  input wire logic [4:0] power_channel_outputs_o,
  input wire logic external_switch_control_output_o,
  input wire logic [2:0] mode_o
);
  int run_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Cycles the forcing input has stayed high
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_r <= 0;
    end else begin
      run_r <= fail_force_i ? run_r + 1 : 0;
    end
  end
  // Supply and ground loss
  property p_off;
    (!battery_supply_ok_i && !logic_supply_ok_i) [*5] |-> mode_o == MODE_POWER_OFF &&
      power_channel_outputs_o == 5'h00 && !external_switch_control_output_o;
  endproperty
  a_off: assert property (p_off) else $error("power-off state wrong");
  property p_bat;
    !battery_supply_ok_i [*5] |-> power_channel_outputs_o == 5'h00 && !clk_pin_oe_o;
  endproperty
  a_bat: assert property (p_bat) else $error("battery loss state wrong");
  property p_gnd;
    !ground_ok_i [*5] |-> power_channel_outputs_o == 5'h00 && mode_o inside {MODE_GND_LOSS, MODE_POWER_OFF};
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground loss state wrong");
  // Forcing input and channel sources
  property p_fail;
    (ground_ok_i && logic_supply_ok_i) [*6] ##0 run_r == DGL_HOLD + 6 |-> mode_o == MODE_FAIL;
  endproperty
  a_fail: assert property (p_fail) else $error("forced fail not entered");
  property p_pwm;
    (mode_o == MODE_NORMAL && pwm_channel_i == 5'h00) [*2] |-> power_channel_outputs_o == 5'h00;
  endproperty
  a_pwm: assert property (p_pwm) else $error("normal outputs not from pwm");
  // Wake report on the clock pin
  property p_drv;
    (wake_i && !wake_by_reset_pin_i && !active_low_reset_pin_n_i && battery_supply_ok_i) [*5]
      |-> clk_pin_oe_o && clk_pin_o;
  endproperty
  a_drv: assert property (p_drv) else $error("wake not driven high");
  property p_inp;
    (!wake_i || wake_by_reset_pin_i) [*5] |-> !clk_pin_oe_o;
  endproperty
  a_inp: assert property (p_inp) else $error("clock pin driven as input");
  property p_rel;
    active_low_reset_pin_n_i [*5] |-> !clk_pin_oe_o && !clk_pin_o;
  endproperty
  a_rel: assert property (p_rel) else $error("clock pin driven out of reset");
  c_wdf: cover property (mode_o == MODE_FAIL && run_r == 0);
  c_gnd: cover property (mode_o == MODE_GND_LOSS);
  c_bat: cover property ($fell(battery_supply_ok_i) && logic_supply_ok_i);
endmodule
bind supply_loss_and_fail_mode_control supply_mode_checker #(.DGL_HOLD(DGL_HOLD)) u_supply_mode_checker (.*);
`default_nettype wire

// ---- tb/mcu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
  input wire logic sys_clk_i,
  input wire logic oe_i,
  input wire logic drv_i,
  output logic pin_o
);
  logic tog_r = 1'b0;
  // Host clock toggles whenever the device lets go of the pin
  always_ff @(posedge sys_clk_i) tog_r <= ~tog_r;
  assign pin_o = oe_i ? drv_i : tog_r;
endmodule
`default_nettype wire

// ---- tb/test_supply_loss_and_fail_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_supply_loss_and_fail_mode_control
  import supply_mode_pkg::*;
();
  localparam int HOLD = 8;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, oe, drv, pin, ext, irq;
  logic bat = 1'b1, lgc = 1'b1, gnd = 1'b1, wake = 1'b1, frc = 1'b0, wbr = 1'b0, rpn = 1'b0;
  logic [4:0] pwm = 5'h1f;
  logic [4:0] outs;
  logic [7:0] flt = 8'h00;
  logic [3:0] dir = 4'ha;
  logic [2:0] mode;
  logic [14:0] rows [8];
  int n_errors = 0;
  int tests_run = 0;
  int ticks = 0;
  supply_loss_and_fail_mode_control #(.DGL_HOLD(15'(HOLD)), .WD_LIMIT(22'h258)) u_supply_loss_and_fail_mode_control (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
    .battery_supply_ok_i(bat), .logic_supply_ok_i(lgc), .ground_ok_i(gnd), .wake_i(wake),
    .wake_by_reset_pin_i(wbr), .active_low_reset_pin_n_i(rpn), .fail_force_i(frc),
    .direct_channel_inputs_i(dir), .clk_pin_i(pin), .clk_pin_o(drv), .clk_pin_oe_o(oe),
    .pwm_channel_i(pwm), .fault_event_i(flt), .power_channel_outputs_o(outs),
    .external_switch_control_output_o(ext), .mode_o(mode), .irq_o(irq));
  mcu_model u_mcu_model (.sys_clk_i(sys_clk_i), .oe_i(oe), .drv_i(drv), .pin_o(pin));
  always #5 sys_clk_i = ~sys_clk_i;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Single classic bus cycle, result left in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    chk("ack", ack, 1'b1);
    cyc <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Rows: bat log gnd wake force, mode, channels, ext, oe
  initial begin
    rows = '{{5'h1e, MODE_NORMAL, 5'h1f, 2'h3}, {5'h1c, MODE_SLEEP, 5'h00, 2'h0},
      {5'h1a, MODE_GND_LOSS, 5'h00, 2'h1}, {5'h1f, MODE_FAIL, 5'h0a, 2'h1},
      {5'h1b, MODE_GND_LOSS, 5'h00, 2'h1}, {5'h0e, MODE_NORMAL, 5'h00, 2'h2},
      {5'h16, MODE_NORMAL, 5'h1f, 2'h1}, {5'h06, MODE_POWER_OFF, 5'h00, 2'h0}};
    repeat (10) @(posedge sys_clk_i);
    chk("reset mode", mode, MODE_POWER_OFF);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    wb(1'b1, CTRL_ADDR, 32'h7d);
    foreach (rows[i]) begin
      {bat, lgc, gnd, wake, frc} <= rows[i][14:10];
      repeat (24) @(posedge sys_clk_i);
      chk("mode", mode, rows[i][9:7]);
      chk("outs", outs, rows[i][6:2]);
      chk("ext", ext, rows[i][1]);
      chk("oe", oe, rows[i][0]);
      chk("drive", drv, rows[i][0]);
      wb(1'b0, STAT_ADDR, 32'h0);
      chk("stat", {q[8:6], q[4:0]}, lgc ? {gnd, lgc, bat, rows[i][9:7], 1'b0, frc} : 8'h00);
      if (rows[i][0]) chk("pin", q[5], lgc);
    end
    {bat, lgc, gnd, wake, frc} <= 5'h1e;
    repeat (8) @(posedge sys_clk_i);
    wb(1'b1, CTRL_ADDR, 32'h7d);
    wb(1'b1, MASK_ADDR, 32'h200);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    // Short forcing pulse with idle PWM
    frc <= 1'b1;
    pwm <= 5'h00;
    repeat (HOLD - 2) @(posedge sys_clk_i);
    frc <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    chk("glitch", mode, MODE_NORMAL);
    chk("idle", outs, 5'h00);
    rpn <= 1'b1;
    pwm <= 5'h1f;
    repeat (8) @(posedge sys_clk_i);
    chk("released", oe, 1'b0);
    rpn <= 1'b0;
    wbr <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk("pin wake", oe, 1'b0);
    wbr <= 1'b0;
    flt <= 8'hff;
    @(posedge sys_clk_i);
    flt <= 8'h00;
    repeat (4) @(posedge sys_clk_i);
    chk("masked", irq, 1'b0);
    // New direct input pattern, only visible once fail mode is entered
    dir <= 4'h5;
    for (int t = 0; t < 700 && mode !== MODE_FAIL; t++) @(posedge sys_clk_i);
    chk("timeout", mode, MODE_FAIL);
    chk("direct", outs, 5'h05);
    chk("irq", irq, 1'b1);
    wb(1'b0, STAT_ADDR, 32'h0);
    chk("serial fail", q[1], 1'b1);
    wb(1'b0, EVT_ADDR, 32'h0);
    chk("events", {q[9], q[7:0]}, 9'h1ff);
    wb(1'b0, EVT_ADDR, 32'h0);
    chk("cleared", {q[9], q[7:0]}, 9'h000);
    chk("irq off", irq, 1'b0);
    wb(1'b1, CTRL_ADDR, 32'h7f);
    for (int t = 0; t < 50 && mode !== MODE_NORMAL; t++) @(posedge sys_clk_i);
    chk("kick", mode, MODE_NORMAL);
    wb(1'b0, STAT_ADDR, 32'h0);
    chk("serial flag off", q[1], 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
